/* File: bench/host_model.sv */
/*
 * Host development system model: drives the register bus as master and
 * reads a finished trace run out.
 * Assumes one clock shared with the counter block; no wait states.
 */
`include "trace_cfg.svh"

module host_model (
    input  wire logic                   clock,
    output logic [`TVC_ADDR_W-1:0]      addr,
    output logic [`TVC_DATA_W-1:0]      wdata,
    output logic                        wr_strobe,
    output logic                        rd_strobe,
    input  wire logic [`TVC_DATA_W-1:0] rdata_q
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        addr      = 16'h0000;
        wdata     = 8'h00;
        wr_strobe = 1'h0;
        rd_strobe = 1'h0;
    end

    task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        addr      <= a;
        wdata     <= d;
        wr_strobe <= 1'h1;
        @(posedge clock);
        wr_strobe <= 1'h0;
        // Released lines show no stale value
        addr      <= ~a;
        wdata     <= ~d;
    endtask

    task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock);
        addr      <= a;
        rd_strobe <= 1'h1;
        @(posedge clock);
        rd_strobe <= 1'h0;
        addr      <= ~a;
        #1;
        d = rdata_q;
    endtask

    // Count first, then that many fetches; buffer lies outside, count re-read
    task automatic drain(output logic [7:0] n, output logic [7:0] last);
        read_reg(`OFF_VALID_COUNT, n);
        last = n;
        for (int i = 0; i < n; i++) begin
            read_reg(`OFF_VALID_COUNT, last);
        end
    endtask
endmodule

/* File: bench/trace_fifo_valid_count_bench.sv */
/*
 * Self-checking bench for the trace valid-word counter.
 * Assumes host_model drives the register bus; bench drives capture side.
 */
`include "trace_cfg.svh"
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module trace_fifo_valid_count_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'h0;
    logic        nrst = 1'h0;
    logic        ce = 1'h1;
    logic        trigger_hit = 1'h0;
    logic        capture_word = 1'h0;
    logic        end_run_reset = 1'h0;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr_strobe;
    logic        rd_strobe;
    logic [7:0]  rdata_q;
    logic        armed_flag;
    logic        store_enable;
    logic        count_full;
    logic [7:0]  v;
    logic [7:0]  w;
    int          fails = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #4 clock = ~clock;

    host_model i_host_model (.clock(clock), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata_q(rdata_q));

    trace_fifo_valid_count i_trace_fifo_valid_count (.clock(clock), .nrst(nrst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .rdata_q(rdata_q), .trigger_hit(trigger_hit), .capture_word(capture_word),
        .end_run_reset(end_run_reset), .armed_flag(armed_flag),
        .store_enable(store_enable), .count_full(count_full));

    task automatic complete_run();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Ceiling well above the hundred or so cycles the scenarios need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            complete_run();
        end
    end

    task automatic capture(input int k);
        repeat (k) begin
            @(posedge clock);
            capture_word <= 1'h1;
        end
        @(posedge clock);
        capture_word <= 1'h0;
    endtask

    task automatic trigger();
        @(posedge clock);
        trigger_hit <= 1'h1;
        @(posedge clock);
        trigger_hit <= 1'h0;
        #1;
    endtask

    task automatic do_reset(input logic end_run);
        @(posedge clock);
        end_run_reset <= end_run;
        nrst          <= 1'h0;
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        repeat (2) @(posedge clock);
        end_run_reset <= 1'h0;
    endtask

    task automatic end_mode_run();
        i_host_model.write_reg(`OFF_CONTROL, 8'hC0);
        #1;
        `CHECK(store_enable, 1'h1)
        i_host_model.read_reg(`OFF_STATUS, v);
        `CHECK(v[`STAT_ARMED_BIT], 1'h1)
        capture(3);
        i_host_model.write_reg(`OFF_VALID_COUNT, 8'hFF);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h03)
        trigger();
        `CHECK(store_enable, 1'h0)
        capture(2);
        i_host_model.drain(v, w);
        `CHECK(v, 8'h03)
        `CHECK(w, 8'h03)
    endtask

    task automatic begin_mode_run();
        i_host_model.write_reg(`OFF_CONTROL, 8'hE0);
        capture(1);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h00)
        trigger();
        `CHECK(store_enable, 1'h1)
        capture(10);
        #1;
        `CHECK(count_full, 1'h1)
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h08)
    endtask

    task automatic disabled_run();
        i_host_model.write_reg(`OFF_CONTROL, 8'h40);
        #1;
        `CHECK(armed_flag, 1'h0)
        capture(2);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h08)
        i_host_model.read_reg(16'h3000, v);
        `CHECK(v, 8'h00)
    endtask

    task automatic end_run_keep();
        i_host_model.write_reg(`OFF_CONTROL, 8'hC0);
        capture(5);
        do_reset(1'h1);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h05)
        do_reset(1'h0);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h00)
    endtask

    // Clock enable low must freeze captures and bus writes alike
    task automatic ce_freeze_run();
        i_host_model.write_reg(`OFF_CONTROL, 8'hC0);
        @(posedge clock);
        ce <= 1'h0;
        capture(3);
        i_host_model.write_reg(`OFF_CONTROL, 8'h00);
        #1;
        `CHECK(store_enable, 1'h1)
        @(posedge clock);
        ce <= 1'h1;
        capture(2);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h02)
    endtask

    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'h1;
        repeat (2) @(posedge clock);
        i_host_model.read_reg(`OFF_VALID_COUNT, v);
        `CHECK(v, 8'h00)
        end_mode_run();
        begin_mode_run();
        disabled_run();
        end_run_keep();
        ce_freeze_run();
        complete_run();
    end
endmodule

/* File: hw/trace_cfg.svh */
/*
 * Constants for the trace capture valid-word counter: register map,
 * field positions, reset values and counter limits.
 * Assumes it is included by bare name from the package and the design.
 */
// Contract
// - After power-on or a reset that does not end a trace run the count reads as zero.
// - After a reset that ends a trace run the count value is not guaranteed.
// - With the unit enabled and end-trigger mode selected, a run ending in reset keeps the count.
// - Bits 7 to 4 of the count register are read-only and read as zero.
// - Bits 3 to 0 give the number of valid captured words in binary, from zero to eight.
// - The count stops at eight and stays there while more words are captured.
// - Arming the unit clears the count to zero.
// - Each captured word adds one to the count, up to the limit.
// - Reading words out of the trace buffer never lowers the count.
// - Arming, triggering and storing happen only while the unit enable bit is set.
// - The unit is split into comparators, trigger control and capture buffer.
// - The begin bit makes a trigger start storing when set and stop storing when clear.
// - While enabled, the armed flag mirrors the arm bit of the control register; here it falls when a run stops on a trigger or at eight words.
`ifndef TRACE_CFG_SVH
`define TRACE_CFG_SVH

`define TVC_ADDR_W       16
`define TVC_DATA_W       8
`define TVC_CNT_W        4

`define OFF_VALID_COUNT  16'h301F
`define OFF_CONTROL      16'h3010
`define OFF_STATUS       16'h3011

`define CTRL_ENABLE_BIT  7
`define CTRL_ARM_BIT     6
`define CTRL_BEGIN_BIT   5
`define STAT_ARMED_BIT   0
`define STAT_STORE_BIT   1
`define STAT_ENABLE_BIT  2

`define COUNT_ZERO       4'h0
`define COUNT_ONE        4'h1
`define COUNT_MAX        4'h8
`define COUNT_UPPER_ZERO 4'h0
`define BYTE_ZERO        8'h00

`endif

/* File: hw/trace_fifo_valid_count.sv */
/*
 * Valid-word counter and run control for the trace capture buffer of the
 * on-chip debug unit, with its control, status and count registers.
 * Assumes trigger_hit comes from the comparator block and capture_word
 * from the buffer data path, both on this clock; end_run_reset is held by
 * the reset controller through the release of nrst.
 */
`include "trace_cfg.svh"

module trace_fifo_valid_count
    import trace_pkg::*;
(
    input  wire logic                    clock,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic [`TVC_ADDR_W-1:0]  addr,
    input  wire logic [`TVC_DATA_W-1:0]  wdata,
    input  wire logic                    wr_strobe,
    input  wire logic                    rd_strobe,
    output logic      [`TVC_DATA_W-1:0]  rdata_q,
    input  wire logic                    trigger_hit,
    input  wire logic                    capture_word,
    input  wire logic                    end_run_reset,
    output logic                         armed_flag,
    output logic                         store_enable,
    output logic                         count_full
);

    function automatic tally_type sat_inc(input tally_type v);
        sat_inc = (v >= `COUNT_MAX) ? `COUNT_MAX : tally_type'(v + `COUNT_ONE);
    endfunction

    function automatic logic hit(input logic [`TVC_ADDR_W-1:0] a,
                                 input logic [`TVC_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic          debug_unit_enable_q;
    logic          begin_mode_q;
    run_state_type run_q;
    run_state_type run_d;
    tally_type     valid_word_tally_q;
    tally_type     tally_d;
    logic          boot_q;
    logic          keep_snap_q;
    logic          armed_flag_q;
    logic          store_enable_q;
    logic          count_full_q;
    logic          ctrl_wr;
    logic          arm_start;
    logic          capture_ok;
    logic          keep_through_reset;

    assign ctrl_wr   = wr_strobe && hit(addr, `OFF_CONTROL);
    // Re-writing the arm bit during a run does not restart it
    assign arm_start = ctrl_wr && wdata[`CTRL_ENABLE_BIT] && wdata[`CTRL_ARM_BIT]
                       && (run_q == RUN_IDLE);
    // Comparators and capture buffer live outside this block
    assign capture_ok = capture_word && debug_unit_enable_q
                        && (run_q == RUN_STORE);
    assign keep_through_reset = end_run_reset && keep_snap_q;

    // Control register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            debug_unit_enable_q <= 1'b0;
            begin_mode_q        <= 1'b0;
        end else if (ce && ctrl_wr) begin
            debug_unit_enable_q <= wdata[`CTRL_ENABLE_BIT];
            begin_mode_q        <= wdata[`CTRL_BEGIN_BIT];
        end
    end

    // Run sequencing
    always_comb begin
        run_d = run_q;
        if (ctrl_wr && !(wdata[`CTRL_ENABLE_BIT] && wdata[`CTRL_ARM_BIT])) begin
            run_d = RUN_IDLE;
        end else if (arm_start) begin
            run_d = wdata[`CTRL_BEGIN_BIT] ? RUN_WAIT_TRIG : RUN_STORE;
        end else if (!debug_unit_enable_q) begin
            run_d = RUN_IDLE;
        end else begin
            case (run_q)
                RUN_WAIT_TRIG: begin
                    if (trigger_hit) begin
                        run_d = RUN_STORE;
                    end
                end
                RUN_STORE: begin
                    if (!begin_mode_q && trigger_hit) begin
                        run_d = RUN_IDLE;
                    end else if (begin_mode_q && tally_d == `COUNT_MAX) begin
                        run_d = RUN_IDLE;
                    end
                end
                default: begin
                    run_d = run_q;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            run_q <= RUN_IDLE;
        end else if (ce) begin
            run_q <= run_d;
        end
    end

    // Count next value
    always_comb begin
        tally_d = valid_word_tally_q;
        if (arm_start) begin
            tally_d = `COUNT_ZERO;
        end else if (capture_ok) begin
            tally_d = sat_inc(valid_word_tally_q);
        end
    end

    // Marks the first enabled edge after reset release
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            boot_q <= 1'b1;
        end else if (ce) begin
            boot_q <= 1'b0;
        end
    end

    // Left without async reset so an end-trigger run can carry it through reset
    always_ff @(posedge clock) begin
        if (ce && !boot_q) begin
            keep_snap_q <= debug_unit_enable_q && !begin_mode_q;
        end
    end

    // Buffer readout has no path in here, so only arming or an ordinary reset lowers the count
    always_ff @(posedge clock) begin
        if (ce) begin
            if (boot_q) begin
                if (!keep_through_reset) begin
                    valid_word_tally_q <= `COUNT_ZERO;
                end
            end else begin
                valid_word_tally_q <= tally_d;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            armed_flag_q   <= 1'b0;
            store_enable_q <= 1'b0;
            count_full_q   <= 1'b0;
        end else if (ce) begin
            armed_flag_q   <= (run_d != RUN_IDLE);
            store_enable_q <= (run_d == RUN_STORE);
            count_full_q   <= !boot_q && (tally_d == `COUNT_MAX);
        end
    end

    assign armed_flag   = armed_flag_q;
    assign store_enable = store_enable_q;
    assign count_full   = count_full_q;

    // Read port; data stand only in the cycle after the strobe
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= `BYTE_ZERO;
        end else if (ce) begin
            rdata_q <= `BYTE_ZERO;
            if (rd_strobe) begin
                if (hit(addr, `OFF_VALID_COUNT)) begin
                    rdata_q <= {`COUNT_UPPER_ZERO, valid_word_tally_q};
                end else if (hit(addr, `OFF_CONTROL)) begin
                    rdata_q[`CTRL_ENABLE_BIT] <= debug_unit_enable_q;
                    rdata_q[`CTRL_ARM_BIT]    <= armed_flag_q;
                    rdata_q[`CTRL_BEGIN_BIT]  <= begin_mode_q;
                end else if (hit(addr, `OFF_STATUS)) begin
                    rdata_q[`STAT_ARMED_BIT]  <= armed_flag_q;
                    rdata_q[`STAT_STORE_BIT]  <= store_enable_q;
                    rdata_q[`STAT_ENABLE_BIT] <= debug_unit_enable_q;
                end
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Antecedents leave out ctrl_wr where a same-cycle control write
    // legally overrides a trigger or a capture
    a_count_bounded: assert property (
        !boot_q |-> valid_word_tally_q <= `COUNT_MAX)
        else $error("valid count above eight");

    a_count_step_up: assert property (
        ce && !boot_q && capture_ok && !arm_start && valid_word_tally_q < `COUNT_MAX
        |=> valid_word_tally_q == tally_type'($past(valid_word_tally_q) + `COUNT_ONE))
        else $error("captured word did not add one");

    a_count_holds_full: assert property (
        ce && !boot_q && !arm_start && valid_word_tally_q == `COUNT_MAX
        |=> valid_word_tally_q == `COUNT_MAX)
        else $error("full count did not hold");

    a_arm_clears_count: assert property (
        ce && !boot_q && arm_start |=> valid_word_tally_q == `COUNT_ZERO)
        else $error("arming did not clear count");

    a_count_never_falls: assert property (
        ce && !boot_q && !arm_start
        |=> valid_word_tally_q >= $past(valid_word_tally_q))
        else $error("count decreased without arming");

    a_count_only_capture: assert property (
        ce && !boot_q && !arm_start && !capture_ok |=> $stable(valid_word_tally_q))
        else $error("count moved without a capture");

    a_idle_ignores_words: assert property (
        ce && !boot_q && !arm_start && run_q != RUN_STORE
        |=> $stable(valid_word_tally_q))
        else $error("word counted outside a store phase");

    a_full_flag_match: assert property (
        ce && !boot_q |=> count_full_q == (valid_word_tally_q == `COUNT_MAX))
        else $error("full flag disagrees with count");

    a_full_means_eight: assert property (
        count_full_q |-> valid_word_tally_q == `COUNT_MAX)
        else $error("full flag set below eight");

    a_begin_stops_full: assert property (
        ce && capture_ok && begin_mode_q
        && valid_word_tally_q == (`COUNT_MAX - `COUNT_ONE)
        |=> !store_enable_q && count_full_q)
        else $error("begin run did not stop at eight");

    // Reset and boot
    a_boot_clears_count: assert property (
        ce && boot_q && !keep_through_reset |=> valid_word_tally_q == `COUNT_ZERO)
        else $error("count not zero after ordinary reset");

    a_boot_keeps_count: assert property (
        ce && boot_q && keep_through_reset |=> $stable(valid_word_tally_q))
        else $error("count lost through end-trace reset");

    a_snapshot_tracks: assert property (
        ce && !boot_q
        |=> keep_snap_q == ($past(debug_unit_enable_q) && !$past(begin_mode_q)))
        else $error("end-trace keep condition not captured");

    a_boot_outputs_low: assert property (
        ce && boot_q && !ctrl_wr |=> !armed_flag_q && !store_enable_q && !count_full_q)
        else $error("flags not clear after ordinary reset");

    // Register port
    a_count_read_back: assert property (
        ce && rd_strobe && hit(addr, `OFF_VALID_COUNT)
        |=> rdata_q == {`COUNT_UPPER_ZERO, $past(valid_word_tally_q)})
        else $error("count read wrong or upper bits set");

    a_write_ignored: assert property (
        ce && !boot_q && wr_strobe && hit(addr, `OFF_VALID_COUNT) && !capture_ok
        |=> $stable(valid_word_tally_q))
        else $error("write changed the count");

    a_read_one_cycle: assert property (
        ce && !rd_strobe |=> rdata_q == `BYTE_ZERO)
        else $error("read data stood past its cycle");

    a_status_read: assert property (
        ce && rd_strobe && hit(addr, `OFF_STATUS)
        |=> rdata_q[`STAT_ARMED_BIT] == $past(armed_flag_q))
        else $error("status armed bit wrong");

    a_control_read: assert property (
        ce && rd_strobe && hit(addr, `OFF_CONTROL)
        |=> rdata_q[`CTRL_ARM_BIT] == $past(armed_flag_q)
        && rdata_q[`CTRL_ENABLE_BIT] == $past(debug_unit_enable_q))
        else $error("control read-back wrong");

    // Run control and flags
    a_disabled_idle: assert property (
        ce && !debug_unit_enable_q && !ctrl_wr
        |=> !store_enable_q && !armed_flag_q)
        else $error("store or arm while disabled");

    a_armed_needs_enable: assert property (
        (armed_flag_q || store_enable_q) |-> debug_unit_enable_q)
        else $error("armed or storing while disabled");

    a_disarm_write: assert property (
        ce && ctrl_wr && !(wdata[`CTRL_ENABLE_BIT] && wdata[`CTRL_ARM_BIT])
        |=> !armed_flag_q && !store_enable_q)
        else $error("disarm write left the unit armed");

    a_armed_mirror: assert property (
        armed_flag_q == (run_q != RUN_IDLE)
        && (!armed_flag_q || debug_unit_enable_q || $past(ctrl_wr)))
        else $error("armed flag out of step");

    a_store_means_armed: assert property (
        store_enable_q |-> armed_flag_q)
        else $error("storing without being armed");

    a_arm_end_mode: assert property (
        ce && arm_start && !wdata[`CTRL_BEGIN_BIT] |=> armed_flag_q && store_enable_q)
        else $error("end-trigger arm did not start storing");

    a_arm_begin_mode: assert property (
        ce && arm_start && wdata[`CTRL_BEGIN_BIT] |=> armed_flag_q && !store_enable_q)
        else $error("begin-trigger arm stored before trigger");

    a_end_trigger_stops: assert property (
        ce && run_q == RUN_STORE && !begin_mode_q && debug_unit_enable_q
        && trigger_hit && !ctrl_wr
        |=> !store_enable_q ##0 run_q == RUN_IDLE)
        else $error("end trigger did not stop storing");

    a_begin_trigger_starts: assert property (
        ce && run_q == RUN_WAIT_TRIG && debug_unit_enable_q && trigger_hit && !ctrl_wr
        |=> store_enable_q)
        else $error("begin trigger did not start storing");

    // Main scenarios
    c_fill_to_eight: cover property (
        store_enable_q && begin_mode_q ##1 count_full_q);

    c_end_trigger_run: cover property (
        arm_start && !wdata[`CTRL_BEGIN_BIT] ##[1:20] (trigger_hit && run_q == RUN_STORE));

    c_keep_through_reset: cover property (
        boot_q && ce && keep_through_reset && valid_word_tally_q != `COUNT_ZERO);

    c_arm_clears_nonzero: cover property (
        ce && arm_start && valid_word_tally_q != `COUNT_ZERO);

    c_frozen_capture: cover property (
        !ce && capture_word && store_enable_q);

endmodule

/* File: hw/trace_pkg.sv */
/*
 * Types shared by the trace valid-word counter.
 * Assumes trace_cfg.svh is on the include path.
 */
`include "trace_cfg.svh"

package trace_pkg;

    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT_TRIG,
        RUN_STORE
    } run_state_type;

    typedef logic [`TVC_CNT_W-1:0] tally_type;

endpackage
